// ==== sim/fbc_bridge_model.sv ====
// Far-side model: the four bridge switches, flagging unsafe gate patterns
`timescale 1ns/100ps
module fbc_bridge_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic high_left_gate,
  input wire logic high_right_gate,
  input wire logic low_left_gate,
  input wire logic low_right_gate,
  output logic fault_r
);
  logic [3:0] g;
  logic [3:0] prev_r;

  assign g = {high_left_gate, high_right_gate, low_left_gate, low_right_gate};

  // A leg with both switches on shorts the supply; a turn-on in the same edge as a
  // turn-off risks the same; low-side-only patterns are legal inside the gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 4'h0;
      fault_r <= 1'b0;
    end else begin
      prev_r <= g;
      if ((g[3] && g[1]) || (g[2] && g[0]) || (((g & ~prev_r) != 4'h0) &&
          ((prev_r & ~g) != 4'h0))) begin
        fault_r <= 1'b1;
      end
      if ((g[3] || g[2]) && !(g inside {4'h9, 4'h6})) begin
        fault_r <= 1'b1;
      end
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the full-bridge commutation block
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] d;
  logic pready, pslverr, hl, hr, ll, lr, fault;
  // Pin order matches the pin register: timing node, drive, bridge off, divider off,
  // start-up delay, supply
  logic [5:0] pin = 6'h12;
  logic [32:0] aq[$];
  logic [3:0] gq[$];
  int fail_count = 0;
  int checked = 0;
  int age = 0;
  int seed = 32'h933E;

  always #5 pclk = ~pclk;

  fbc_commutation DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_drive_input(pin[1]),
    .divider_disable_input(pin[3]), .bridge_disable_input(pin[2]),
    .startup_delay_input(pin[4]), .oscillator_timing_node(pin[0]), .supply_ok_input(pin[5]),
    .high_left_gate(hl), .high_right_gate(hr), .low_left_gate(ll), .low_right_gate(lr));

  fbc_bridge_model bridge (.pclk(pclk), .presetn(presetn), .high_left_gate(hl),
    .high_right_gate(hr), .low_left_gate(ll), .low_right_gate(lr), .fault_r(fault));

  task automatic conclude();
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Oldest note meets each bus answer or gate pattern; a pattern late by more than 40 cycles fails
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      `CHK("apb", aq[0], {pslverr, prdata})
      void'(aq.pop_front());
    end
    if (gq.size() > 0) begin
      age++;
      if ({hl, hr, ll, lr} === gq[0] || age > 40) begin
        `CHK("gates", gq[0], {hl, hr, ll, lr})
        void'(gq.pop_front());
        age = 0;
      end
    end
  end

  task automatic setp(input int k, input logic v);
    @(posedge pclk);
    pin[k] <= v;
  endtask

  task automatic gexp(input logic [3:0] p);
    gq.push_back(p);
    for (int i = 0; i < 60 && gq.size() > 0; i++) @(posedge pclk);
  endtask

  // Falling edge must flip the bridge; the rising edge that follows must not
  task automatic pulse(input int k, input logic [3:0] p);
    setp(k, 1'b0);
    gexp(p);
    repeat ($random(seed) & 7) @(posedge pclk);
    setp(k, 1'b1);
    repeat (10) @(posedge pclk);
    gexp(p);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                     input logic [32:0] e);
    int n;
    n = 0;
    aq.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask

  initial begin
    #500000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    gexp(4'h3);
    setp(2, 1'b1);
    gexp(4'h0);
    setp(2, 1'b0);
    gexp(4'h3);
    setp(5, 1'b1);
    gexp(4'h9);
    // External clock through the divider, timing node held low
    for (int i = 0; i < 3; i++) pulse(1, i[0] ? 4'h9 : 4'h6);
    // Internal oscillator, drive input held high
    setp(0, 1'b1);
    for (int i = 0; i < 2; i++) pulse(0, i[0] ? 4'h6 : 4'h9);
    setp(2, 1'b1);
    gexp(4'h0);
    setp(2, 1'b0);
    gexp(4'h9);
    setp(3, 1'b1);
    gexp(4'h6);
    setp(1, 1'b0);
    gexp(4'h9);
    setp(1, 1'b1);
    gexp(4'h6);
    setp(4, 1'b0);
    gexp(4'h3);
    setp(4, 1'b1);
    gexp(4'h6);
    setp(5, 1'b0);
    gexp(4'h3);
    d = ($random(seed) & 32'hFFFFFFFC) | 32'h1;
    apb(1'b1, 12'h000, d, 33'h0);
    gexp(4'h0);
    apb(1'b0, 12'h000, 32'h0, 33'h1);
    apb(1'b0, 12'h008, 32'h0, {27'h0, pin});
    apb(1'b1, 12'h004, d, {1'b1, 32'h0});
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    gexp(4'h3);
    // Status in start-up: low sides on, position from the high drive input
    apb(1'b0, 12'h004, 32'h0, 33'h34);
    setp(5, 1'b1);
    gexp(4'h6);
    apb(1'b1, 12'h000, 32'h2, 33'h0);
    gexp(4'h3);
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    gexp(4'h6);
    apb(1'b0, 12'h004, 32'h0, 33'h67);
    // Clock enable low must freeze the bridge against a drive input change
    clk_en <= 1'b0;
    setp(1, 1'b0);
    repeat (20) @(posedge pclk);
    gexp(4'h6);
    clk_en <= 1'b1;
    gexp(4'h9);
    repeat (4) @(posedge pclk);
    `CHK("fault", 1'b0, fault)
    `CHK("left", 0, aq.size() + gq.size())
    conclude();
  end
endmodule

// ==== src/fbc_commutation.sv ====
// Full-bridge commutation controller with APB register access
`timescale 1ns/100ps
`include "fbc_params.svh"

module fbc_commutation
  import fbc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NONOVERLAP_CYCLES = `FBC_NONOVERLAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_drive_input,
  input wire logic divider_disable_input,
  input wire logic bridge_disable_input,
  input wire logic startup_delay_input,
  input wire logic oscillator_timing_node,
  input wire logic supply_ok_input,
  output logic high_left_gate,
  output logic high_right_gate,
  output logic low_left_gate,
  output logic low_right_gate
);

  localparam int CNT_W = 8;

  // Elaboration check: interval must be at least one cycle and fit the counter
  if (NONOVERLAP_CYCLES < 1 || NONOVERLAP_CYCLES > 255) begin : g_bad_nonoverlap
    $error("NONOVERLAP_CYCLES out of range 1..255");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must be at least 4");
  end

  logic [`FBC_PIN_COUNT-1:0] pins_raw;
  logic [`FBC_PIN_COUNT-1:0] meta_r;
  logic [`FBC_PIN_COUNT-1:0] sync_r;
  logic ext_dly_r;
  logic osc_dly_r;
  logic [1:0] ctrl_r;
  fbc_state_t state_r;
  logic pos_r;
  logic released_r;
  logic [3:0] gates_r;
  logic [3:0] gates_nxt;
  logic [CNT_W-1:0] dead_r;
  logic [CNT_W-1:0] dead_nxt;
  logic [3:0] target;
  logic dis_eff;
  logic su_high;
  logic div_en;
  logic fall_evt;
  logic released_nxt;
  logic pos_nxt;
  logic [ADDR_W-1:0] ofs;
  logic [31:0] rd_val;
  logic rd_hit;

  assign pins_raw = {supply_ok_input, startup_delay_input, divider_disable_input,
                     bridge_disable_input, external_drive_input, oscillator_timing_node};

  // Two-flop synchronisers, one per pin; the first stage feeds only the second
  genvar gi;
  for (gi = 0; gi < `FBC_PIN_COUNT; gi++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_r[gi] <= 1'b0;
        sync_r[gi] <= 1'b0;
      end else if (clk_en) begin
        meta_r[gi] <= pins_raw[gi];
        sync_r[gi] <= meta_r[gi];
      end
    end
  end

  // Delayed copies of the synchronised clock sources for falling-edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_dly_r <= 1'b0;
      osc_dly_r <= 1'b0;
    end else if (clk_en) begin
      ext_dly_r <= sync_r[`FBC_PIN_EXT];
      osc_dly_r <= sync_r[`FBC_PIN_OSC];
    end
  end

  // Pin disable and software disable act alike
  assign dis_eff = sync_r[`FBC_PIN_BRIDGE_DIS] | ctrl_r[`FBC_CTRL_SW_DISABLE];
  // Software hold stretches the start-up delay like a low pin would
  assign su_high = sync_r[`FBC_PIN_START_DLY] & ~ctrl_r[`FBC_CTRL_SW_HOLD];
  assign div_en = ~sync_r[`FBC_PIN_DIV_DIS];
  // Only one source toggles in practice: the unused one is tied static
  assign fall_evt = (osc_dly_r & ~sync_r[`FBC_PIN_OSC]) |
                    (ext_dly_r & ~sync_r[`FBC_PIN_EXT]);

  // Supply-level state; the supply comparator carries its own hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FBC_ST_STARTUP;
    end else if (clk_en) begin
      if (!sync_r[`FBC_PIN_SUPPLY]) begin
        state_r <= FBC_ST_STARTUP;
      end else begin
        state_r <= FBC_ST_OSCILLATE;
      end
    end
  end

  // Bridge position: divider toggles, or direct follow of the drive input
  always_comb begin
    released_nxt = (state_r == FBC_ST_OSCILLATE) && su_high && !dis_eff;
    pos_nxt = pos_r;
    if (!released_nxt || !released_r) begin
      // Restart from the predefined position; without divider take the input level
      // Drive input high selects the high-right and low-left pair
      pos_nxt = div_en ? 1'b0 : sync_r[`FBC_PIN_EXT];
    end else if (!div_en) begin
      pos_nxt = sync_r[`FBC_PIN_EXT];
    end else if (fall_evt) begin
      pos_nxt = ~pos_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      released_r <= 1'b0;
      pos_r <= 1'b0;
    end else if (clk_en) begin
      released_r <= released_nxt;
      pos_r <= pos_nxt;
    end
  end

  // Wanted gate pattern; disable outranks everything
  always_comb begin
    if (dis_eff) begin
      target = `FBC_PAT_OFF;
    end else if (!released_r) begin
      target = `FBC_PAT_STARTUP;
    end else begin
      target = pos_r ? `FBC_PAT_B : `FBC_PAT_A;
    end
  end

  // Break before make: turn-offs land at once, turn-ons wait for the interval
  always_comb begin
    gates_nxt = gates_r;
    dead_nxt = dead_r;
    if ((gates_r & ~target) != 4'h0) begin
      gates_nxt = gates_r & target;
      dead_nxt = CNT_W'(NONOVERLAP_CYCLES);
    end else if (dead_r != '0) begin
      dead_nxt = dead_r - 1'b1;
    end else begin
      gates_nxt = target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates_r <= `FBC_PAT_OFF;
      dead_r <= '0;
    end else if (clk_en) begin
      gates_r <= gates_nxt;
      dead_r <= dead_nxt;
    end
  end

  // Gate pins come straight from the pattern register, so no decode glitch reaches a driver
  assign high_left_gate = gates_r[3];
  assign high_right_gate = gates_r[2];
  assign low_left_gate = gates_r[1];
  assign low_right_gate = gates_r[0];

  // APB read mux; reserved bits read zero
  assign ofs = paddr;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ofs)
      `FBC_CTRL_OFS: rd_val[1:0] = ctrl_r;
      `FBC_STATUS_OFS: begin
        rd_val[`FBC_ST_RUNNING] = (state_r == FBC_ST_OSCILLATE);
        rd_val[`FBC_ST_RELEASED] = released_r;
        rd_val[`FBC_ST_POSITION] = pos_r;
        rd_val[`FBC_ST_DEAD] = (dead_r != '0);
        rd_val[`FBC_ST_GATES_LO +: 4] = gates_r;
      end
      `FBC_PINS_OFS: rd_val[`FBC_PIN_COUNT-1:0] = sync_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait-free access phase: answer is ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        // Status is read-only, so a write there is an error like an unmapped one
        pslverr <= !rd_hit || (pwrite && ofs != `FBC_CTRL_OFS);
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Control register write at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `FBC_CTRL_RESET;
    end else if (clk_en) begin
      if (psel && penable && pready && pwrite && ofs == `FBC_CTRL_OFS) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

  AST_STARTUP_HIGHS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !released_r |=> !high_left_gate && !high_right_gate)
    else $error("high-side gate on while not released");

  AST_DISABLE_ALL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && dis_eff |=> gates_r == `FBC_PAT_OFF)
    else $error("gate on while bridge disabled");

  AST_STARTUP_LOWS_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !dis_eff && !released_r)[*4] |=> low_left_gate && low_right_gate)
    else $error("low sides not on during start-up");

  AST_SUPPLY_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !sync_r[`FBC_PIN_SUPPLY] |=> state_r == FBC_ST_STARTUP ##1 !released_r)
    else $error("no return to start-up on low supply");

  AST_DIVIDER_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !released_r && released_nxt && div_en |=> !pos_r)
    else $error("divider did not resume at predefined position");

  AST_DIRECT_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && released_nxt && !div_en |=> pos_r == $past(sync_r[`FBC_PIN_EXT]))
    else $error("position does not follow drive input");

  AST_DIV_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && released_r && released_nxt && div_en && fall_evt |=> pos_r != $past(pos_r))
    else $error("divider missed a falling edge");

  AST_DIV_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && released_r && released_nxt && div_en && !fall_evt |=> $stable(pos_r))
    else $error("divider moved without a falling edge");

  AST_TWO_PATTERNS: assert property (@(posedge pclk) disable iff (!presetn)
    high_left_gate || high_right_gate |-> gates_r == `FBC_PAT_A || gates_r == `FBC_PAT_B)
    else $error("high side on outside a diagonal pattern");

  AST_BREAK_BEFORE_MAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (gates_r & ~$past(gates_r)) != 4'h0 |-> (~gates_r & $past(gates_r)) == 4'h0
      && $past(dead_r) == '0)
    else $error("turn-on without preceding non-overlap interval");

  AST_RELEASE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state_r == FBC_ST_OSCILLATE && su_high && !dis_eff |=> released_r)
    else $error("no release although supply, delay and disable allow it");

  AST_DISABLE_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && dis_eff && state_r == FBC_ST_STARTUP |=> gates_r == `FBC_PAT_OFF)
    else $error("start-up pattern shown while bridge disabled");

  AST_DIRECT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !released_r && released_nxt && !div_en |=> pos_r == $past(sync_r[`FBC_PIN_EXT]))
    else $error("direct mode did not start from the drive input level");

  // A turn-on inside the gap would let one leg conduct top and bottom at once
  AST_NO_MAKE_IN_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && dead_r != '0 |=> (gates_r & ~$past(gates_r)) == 4'h0)
    else $error("gate turned on inside the non-overlap interval");

endmodule

// ==== src/fbc_params.svh ====
// Offsets, field positions, reset values and timing counts of the commutation block
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

// Register byte offsets
`define FBC_CTRL_OFS 12'h000
`define FBC_STATUS_OFS 12'h004
`define FBC_PINS_OFS 12'h008

// Control register fields and reset value
`define FBC_CTRL_SW_DISABLE 0
`define FBC_CTRL_SW_HOLD 1
`define FBC_CTRL_RESET 2'h0

// Status register fields
`define FBC_ST_RUNNING 0
`define FBC_ST_RELEASED 1
`define FBC_ST_POSITION 2
`define FBC_ST_DEAD 3
`define FBC_ST_GATES_LO 4

// Synchronised pin index
`define FBC_PIN_OSC 0
`define FBC_PIN_EXT 1
`define FBC_PIN_BRIDGE_DIS 2
`define FBC_PIN_DIV_DIS 3
`define FBC_PIN_START_DLY 4
`define FBC_PIN_SUPPLY 5
`define FBC_PIN_COUNT 6

// Gate patterns, bit 3..0 = high-left, high-right, low-left, low-right
`define FBC_PAT_OFF 4'h0
`define FBC_PAT_STARTUP 4'h3
`define FBC_PAT_A 4'h9
`define FBC_PAT_B 4'h6

// Timing: non-overlap interval and the clock rate
`define FBC_NONOVERLAP_NS 20
`define FBC_CLK_MHZ 100
`define FBC_NONOVERLAP_CYC (((`FBC_NONOVERLAP_NS * `FBC_CLK_MHZ) + 999) / 1000)

`endif

// ==== src/fbc_pkg.sv ====
// Types of the full-bridge commutation block
package fbc_pkg;

  // Supply-level state of the bridge controller
  typedef enum logic [0:0] {
    FBC_ST_STARTUP,
    FBC_ST_OSCILLATE
  } fbc_state_t;

endpackage
